// [sgsc_consts.svh]
// constants for the global start and control register group
`ifndef SGSC_CONSTS_SVH
`define SGSC_CONSTS_SVH
`define SGSC_ADDR_FAMILY 8'h00
`define SGSC_ADDR_CHIP 8'h01
`define SGSC_ADDR_GCTL0 8'h02
`define SGSC_CMD_READ 8'h03
`define SGSC_CMD_WRITE 8'h02
`define SGSC_GCTL0_RESET 7'h44
`define SGSC_BIT_START 0
`define SGSC_BIT_LINK_AGE 0
`define SGSC_BIT_DROP_MODE 1
`define SGSC_BIT_SHARE 2
`define SGSC_BIT_MII_EN 3
`define SGSC_PRIO_LSB 4
`define SGSC_PRIO_MSB 6
`define SGSC_FLOWCTL_TYPE 16'h8808
`define SGSC_FLOWCTL_DA 48'h0180C2000001
`define SGSC_FAST_AGE_NS 800000
`define SGSC_CLK_NS 5
`define SGSC_FAST_AGE_CYC (`SGSC_FAST_AGE_NS / `SGSC_CLK_NS)
`define SGSC_NORMAL_AGE_S 375
`define SGSC_NORMAL_AGE_CYC (`SGSC_NORMAL_AGE_S * 64'd200000000)
`endif

// [sgsc_pkg.sv]
// types for the global start and control register group
package sgsc_pkg;
	typedef enum logic [1:0] {SGSC_CFG_EEPROM, SGSC_CFG_SLAVE_A, SGSC_CFG_SLAVE_B, SGSC_CFG_TEST} sgsc_cfg_t;
	typedef enum {SGSC_LOAD_WAIT, SGSC_LOAD_DONE} sgsc_load_t;
endpackage

// [sgsc_global_ctrl.sv]
// global identification, start and control register group
`timescale 1ns/1ps
`include "sgsc_consts.svh"
module sgsc_global_ctrl #(
	parameter logic [7:0] FAMILY_CODE = 8'hA5, // arbitrary
	parameter logic [3:0] CHIP_CODE = 4'hA, // arbitrary
	parameter logic [2:0] REVISION = 3'h1, // arbitrary
	parameter int FAST_AGE_CYC = `SGSC_FAST_AGE_CYC,
	parameter longint NORMAL_AGE_CYC = `SGSC_NORMAL_AGE_CYC
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic config_select_high,
	input wire logic config_select_low,
	input wire logic mii_enable_strap_pin,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_cmd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic load_done,
	input wire logic load_present,
	input wire logic [7:0] load_family,
	input wire logic [7:0] load_chip,
	input wire logic [7:0] load_gctl0,
	input wire logic [2:0] frame_user_prio,
	input wire logic [15:0] frame_type_len,
	input wire logic [47:0] frame_da,
	input wire logic frame_is_flowctl,
	input wire logic [4:0] port_link_up,
	output logic switch_run,
	output logic frame_high_prio,
	output logic frame_drop,
	output logic mii_out_en_n,
	output logic buffer_share,
	output logic [2:0] port_buffer_fifths,
	output logic fast_age_active,
	output logic age_flush_all,
	output logic age_tick
);
	import sgsc_pkg::*;

	logic [1:0] cfg_s1_q, cfg_s2_q;
	logic strap_s1_q, strap_s2_q;
	logic [4:0] link_s1_q, link_s2_q, link_prev_q;
	logic start_q;
	logic [6:0] gctl0_q;
	logic strap_taken_q;
	sgsc_load_t load_q;
	sgsc_cfg_t cfg;
	logic link_lost;
	logic [31:0] fast_cnt_q;
	logic [63:0] norm_cnt_q;
	logic load_ok;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_s1_q <= 2'h0;
			cfg_s2_q <= 2'h0;
			link_s1_q <= 5'h00;
			link_s2_q <= 5'h00;
			link_prev_q <= 5'h00;
		end else begin
			cfg_s1_q <= {config_select_high, config_select_low};
			cfg_s2_q <= cfg_s1_q;
			link_s1_q <= port_link_up;
			link_s2_q <= link_s1_q;
			link_prev_q <= link_s2_q;
		end
	end

	// strap flops carry no reset so they already hold the pin level on release
	always_ff @(posedge clk) begin
		strap_s1_q <= mii_enable_strap_pin;
		strap_s2_q <= strap_s1_q;
	end

	// pin value 11 is factory test; treated as stopped
	assign cfg = sgsc_cfg_t'(cfg_s2_q);
	assign link_lost = |(link_prev_q & ~link_s2_q);
	assign load_ok = load_present && load_family == FAMILY_CODE && load_chip[7:4] == CHIP_CODE;

	// eeprom load phase; switch_run waits on it only in mode 00
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			load_q <= SGSC_LOAD_WAIT;
		end else begin
			case (load_q)
				SGSC_LOAD_WAIT: if (load_done) load_q <= SGSC_LOAD_DONE;
				SGSC_LOAD_DONE: load_q <= SGSC_LOAD_DONE;
				default: load_q <= SGSC_LOAD_WAIT;
			endcase
		end
	end

	// start bit; id fields are never stored so writes drop
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			start_q <= 1'b0;
		end else if (reg_wr && reg_cmd == `SGSC_CMD_WRITE && reg_addr == `SGSC_ADDR_CHIP) begin
			start_q <= reg_wdata[`SGSC_BIT_START];
		end else if (load_q == SGSC_LOAD_WAIT && load_done && load_ok) begin
			start_q <= load_chip[`SGSC_BIT_START];
		end
	end

	// strap caught after reset release, not in the reset branch
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gctl0_q <= `SGSC_GCTL0_RESET;
			strap_taken_q <= 1'b0;
		end else if (!strap_taken_q) begin
			strap_taken_q <= 1'b1;
			gctl0_q[`SGSC_BIT_MII_EN] <= strap_s2_q;
		end else if (reg_wr && reg_cmd == `SGSC_CMD_WRITE && reg_addr == `SGSC_ADDR_GCTL0) begin
			gctl0_q <= reg_wdata[6:0];
		end else if (load_q == SGSC_LOAD_WAIT && load_done && load_ok) begin
			gctl0_q <= load_gctl0[6:0];
		end
		// failed or absent load leaves defaults
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			switch_run <= 1'b0;
		end else begin
			case (cfg)
				SGSC_CFG_EEPROM: switch_run <= load_q == SGSC_LOAD_DONE;
				SGSC_CFG_SLAVE_A, SGSC_CFG_SLAVE_B: switch_run <= start_q;
				default: switch_run <= 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd && reg_cmd == `SGSC_CMD_READ;
			case (reg_addr)
				`SGSC_ADDR_FAMILY: reg_rdata <= FAMILY_CODE;
				`SGSC_ADDR_CHIP: reg_rdata <= {CHIP_CODE, REVISION, start_q};
				`SGSC_ADDR_GCTL0: reg_rdata <= {1'b0, gctl0_q};
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			frame_high_prio <= 1'b0;
			frame_drop <= 1'b0;
			mii_out_en_n <= 1'b1;
			buffer_share <= 1'b1;
			port_buffer_fifths <= 3'h5;
		end else begin
			frame_high_prio <= frame_user_prio >= gctl0_q[`SGSC_PRIO_MSB:`SGSC_PRIO_LSB];
			if (gctl0_q[`SGSC_BIT_DROP_MODE])
				frame_drop <= frame_type_len == `SGSC_FLOWCTL_TYPE || frame_da == `SGSC_FLOWCTL_DA;
			else
				frame_drop <= frame_is_flowctl;
			mii_out_en_n <= !gctl0_q[`SGSC_BIT_MII_EN];
			buffer_share <= gctl0_q[`SGSC_BIT_SHARE];
			port_buffer_fifths <= gctl0_q[`SGSC_BIT_SHARE] ? 3'h5 : 3'h1;
		end
	end

	// fast age pass lasts FAST_AGE_CYC cycles (800 us), then back to normal period
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fast_cnt_q <= 32'h0;
			fast_age_active <= 1'b0;
			age_flush_all <= 1'b0;
		end else begin
			age_flush_all <= link_lost;
			if (link_lost && gctl0_q[`SGSC_BIT_LINK_AGE]) begin
				fast_age_active <= 1'b1;
				fast_cnt_q <= 32'(FAST_AGE_CYC - 1);
			end else if (fast_age_active) begin
				if (fast_cnt_q == 32'h0)
					fast_age_active <= 1'b0;
				else
					fast_cnt_q <= fast_cnt_q - 32'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			norm_cnt_q <= 64'h0;
			age_tick <= 1'b0;
		end else begin
			age_tick <= 1'b0;
			if (fast_age_active) begin
				norm_cnt_q <= 64'h0;
			end else if (norm_cnt_q >= 64'(NORMAL_AGE_CYC - 1)) begin
				norm_cnt_q <= 64'h0;
				age_tick <= 1'b1;
			end else begin
				norm_cnt_q <= norm_cnt_q + 64'h1;
			end
		end
	end

	stopped_a: assert property (@(posedge clk) disable iff (!reset_n)
		(cfg_s2_q == 2'h2 && !start_q) |=> !switch_run) else $error("run without start");
	run_start_a: assert property (@(posedge clk) disable iff (!reset_n)
		(cfg_s2_q == 2'h1 && start_q) |=> switch_run) else $error("no run after start");
	auto_run_a: assert property (@(posedge clk) disable iff (!reset_n)
		(cfg_s2_q == 2'h0 && load_q == SGSC_LOAD_DONE) |=> switch_run) else $error("no auto start");
	prio_class_a: assert property (@(posedge clk) disable iff (!reset_n)
		##1 frame_high_prio == ($past(frame_user_prio) >= $past(gctl0_q[6:4]))) else $error("bad priority");
	mii_iso_a: assert property (@(posedge clk) disable iff (!reset_n)
		##1 mii_out_en_n == !$past(gctl0_q[3])) else $error("mii enable wrong");
	share_lim_a: assert property (@(posedge clk) disable iff (!reset_n)
		!buffer_share |-> port_buffer_fifths == 3'h1) else $error("share limit");
	drop_mode_a: assert property (@(posedge clk) disable iff (!reset_n)
		(gctl0_q[1] && frame_type_len == 16'h8808) |=> frame_drop) else $error("no drop");
	fc_drop_a: assert property (@(posedge clk) disable iff (!reset_n)
		(!gctl0_q[1] && !frame_is_flowctl) |=> !frame_drop) else $error("extra drop");
	fast_age_a: assert property (@(posedge clk) disable iff (!reset_n)
		(link_lost && gctl0_q[0]) |=> fast_age_active) else $error("no fast age");
	flush_a: assert property (@(posedge clk) disable iff (!reset_n)
		link_lost |=> age_flush_all) else $error("no flush");
	strap_cap_a: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(strap_taken_q) |-> gctl0_q[3] == $past(strap_s2_q)) else $error("strap not taken");
	id_fixed_a: assert property (@(posedge clk) disable iff (!reset_n)
		(reg_rd && reg_cmd == 8'h03 && reg_addr == 8'h00) |=> reg_rdata == FAMILY_CODE) else $error("id");
endmodule

// [sgsc_cfg_loader.sv]
// configuration memory model facing the register group loader port
`timescale 1ns/1ps
module sgsc_cfg_loader (
	input wire logic clk,
	input wire logic go,
	input wire logic present,
	input wire logic [7:0] family,
	output logic load_done,
	output logic load_present,
	output logic [7:0] load_family,
	output logic [7:0] load_chip,
	output logic [7:0] load_gctl0
);
	initial begin
		{load_done, load_present} = 2'b00;
		{load_family, load_chip, load_gctl0} = 24'hA5A5A5;
	end
	always @(posedge go) begin
		repeat (5) @(negedge clk);
		load_present <= present;
		load_family <= present ? family : 8'h5A;
		load_chip <= present ? 8'hA1 : 8'h5A;
		load_gctl0 <= present ? 8'h35 : 8'h5A;
		load_done <= 1'b1;
		@(negedge clk);
		load_done <= 1'b0;
		load_present <= 1'b0;
		// released bytes change so a stale capture shows
		{load_family, load_chip, load_gctl0} <= 24'h5A5A5A;
	end
endmodule

// [testbench.sv]
// self-checking bench for the global start and control register group
`timescale 1ns/1ps
module testbench;
	logic clk = 0, reset_n = 0, csh = 1, csl = 0, strap = 1, wr = 0, rd = 0, go = 0, pres = 0, fc = 0;
	logic [7:0] cmd = 8'h00, addr = 8'h00, wd = 8'h00, rdat, fam = 8'hA5, lf, lc, lg;
	logic rv, ld, lp, run, hp, drop, mii_n, share, fast, flush, tick;
	logic [2:0] prio = 3'h0, fifths;
	logic [15:0] tl = 16'h0000;
	logic [47:0] da = 48'h000000000000;
	logic [4:0] link = 5'h1F;
	int err_total = 0, cmp_count = 0, cyc = 0;
	always #2.5 clk = ~clk;
	sgsc_global_ctrl #(.FAST_AGE_CYC(16), .NORMAL_AGE_CYC(100)) dut_u (.clk(clk), .reset_n(reset_n),
		.config_select_high(csh), .config_select_low(csl), .mii_enable_strap_pin(strap), .reg_wr(wr),
		.reg_rd(rd), .reg_cmd(cmd), .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdat), .reg_rvalid(rv),
		.load_done(ld), .load_present(lp), .load_family(lf), .load_chip(lc), .load_gctl0(lg),
		.frame_user_prio(prio), .frame_type_len(tl), .frame_da(da), .frame_is_flowctl(fc),
		.port_link_up(link), .switch_run(run), .frame_high_prio(hp), .frame_drop(drop),
		.mii_out_en_n(mii_n), .buffer_share(share), .port_buffer_fifths(fifths),
		.fast_age_active(fast), .age_flush_all(flush), .age_tick(tick));
	sgsc_cfg_loader ldr_u (.clk(clk), .go(go), .present(pres), .family(fam), .load_done(ld),
		.load_present(lp), .load_family(lf), .load_chip(lc), .load_gctl0(lg));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rst(input logic hi, input logic lo);
		{csh, csl} = {hi, lo};
		reset_n = 0;
		repeat (2) @(negedge clk);
		reset_n = 1;
		repeat (3) @(negedge clk);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		{wr, cmd, addr, wd} = {1'b1, 8'h02, a, d};
		@(negedge clk);
		wr = 0;
		@(negedge clk);
	endtask
	task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
		int n;
		n = 0;
		{rd, cmd, addr} = {1'b1, 8'h03, a};
		@(negedge clk);
		rd = 0;
		while (rv !== 1'b1 && n < 4) begin
			@(negedge clk);
			n++;
		end
		chk({7'h00, rv}, 8'h01);
		chk(rdat, exp);
	endtask
	task automatic frm(input logic [2:0] p, input logic [15:0] t, input logic f, input logic [1:0] exp);
		{prio, tl, fc} = {p, t, f};
		@(negedge clk);
		chk({6'h00, hp, drop}, {6'h00, exp});
	endtask
	task automatic t_reset;
		rst(1, 0);
		rreg(8'h00, 8'hA5);
		rreg(8'h01, 8'hA2);
		rreg(8'h02, 8'h4C);
		chk({2'b00, run, mii_n, share, fifths}, 8'h0D);
		rreg(8'h40, 8'h00);
	endtask
	task automatic t_start;
		wreg(8'h00, 8'h00);
		rreg(8'h00, 8'hA5);
		wreg(8'h01, 8'hFF);
		rreg(8'h01, 8'hA3);
		chk({7'h00, run}, 8'h01);
		rst(0, 1);
		chk({7'h00, run}, 8'h00);
		wreg(8'h01, 8'h01);
		@(negedge clk);
		chk({7'h00, run}, 8'h01);
	endtask
	task automatic t_ctrl;
		int n;
		rst(1, 0);
		wreg(8'h02, 8'hB3);
		rreg(8'h02, 8'h33);
		chk({3'h0, mii_n, share, fifths}, 8'h11);
		frm(3'h2, 16'h0000, 0, 2'b00);
		frm(3'h3, 16'h0000, 0, 2'b10);
		frm(3'h0, 16'h8808, 0, 2'b01);
		da = 48'h0180C2000001;
		frm(3'h0, 16'h0000, 0, 2'b01);
		da = 48'h000000000000;
		wreg(8'h02, 8'h31);
		frm(3'h0, 16'h8808, 0, 2'b00);
		frm(3'h0, 16'h0000, 1, 2'b01);
		link = 5'h1E;
		n = 0;
		while (flush !== 1'b1 && n < 8) begin
			@(negedge clk);
			n++;
		end
		chk({6'h00, flush, fast}, 8'h03);
		// fast pass is 16 cycles here, so 30 leaves margin
		repeat (30) @(negedge clk);
		chk({7'h00, fast}, 8'h00);
		n = 0;
		while (tick !== 1'b1 && n < 120) begin
			@(negedge clk);
			n++;
		end
		chk({7'h00, tick}, 8'h01);
	endtask
	task automatic ee(input logic p, input logic [7:0] f, input logic [7:0] exp);
		int n;
		{go, pres, fam} = {1'b0, p, f};
		rst(0, 0);
		chk({7'h00, run}, 8'h00);
		go = 1;
		n = 0;
		while (run !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		chk({7'h00, run}, 8'h01);
		rreg(8'h02, exp);
	endtask
	task automatic tally_and_finish;
		$display("errors %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end
	initial begin
		t_reset();
		t_start();
		t_ctrl();
		ee(1, 8'hA5, 8'h35);
		ee(1, 8'h5A, 8'h4C);
		strap = 0;
		ee(0, 8'hA5, 8'h44);
		chk({7'h00, mii_n}, 8'h01);
		tally_and_finish();
	end
endmodule
